// ===== clock_modes_pkg.sv
package clock_modes_pkg;

  // register offsets (byte addresses on apb)
  localparam logic [7:0] off_system_clock_control = 8'h00;
  localparam logic [7:0] off_fast_rc_osc_control  = 8'h04;
  localparam logic [7:0] off_freq_synth_control   = 8'h08;
  localparam logic [7:0] off_mode_status          = 8'h0c;

  // field positions
  localparam int sel_lsb          = 5;   // sys_clk_select in bits 7:5
  localparam int fast_idle_bit    = 1;
  localparam int slow_idle_bit    = 0;
  localparam int fast_osc_en_bit  = 0;
  localparam int fast_osc_rdy_bit = 1;
  localparam int synth_en_bit     = 0;
  localparam int synth_rdy_bit    = 1;
  localparam int synth_fsel_lsb   = 2;   // synth_freq_select in bits 4:2

  // reset values
  localparam logic [2:0] sel_reset       = 3'h2;
  localparam logic       fast_osc_en_rst = 1'b1;
  localparam logic       synth_en_reset  = 1'b1;
  localparam logic [2:0] synth_fsel_rst  = 3'h0;

  // select codes
  localparam logic [2:0] sel_high_div1   = 3'h0;
  localparam logic [2:0] sel_sub         = 3'h7;
  localparam logic [2:0] fsel_6mhz       = 3'h4;
  localparam logic [2:0] fsel_12mhz      = 3'h5;
  localparam logic [2:0] fsel_16mhz      = 3'h6;
  localparam logic [2:0] fsel_reserved   = 3'h7;

  // reported mode codes
  localparam logic [2:0] mode_normal         = 3'h0;
  localparam logic [2:0] mode_slow           = 3'h1;
  localparam logic [2:0] mode_sleep          = 3'h2;
  localparam logic [2:0] mode_idle_slow_only = 3'h3;
  localparam logic [2:0] mode_idle_both_osc  = 3'h4;
  localparam logic [2:0] mode_idle_fast_only = 3'h5;

  // power state
  typedef enum logic [2:0] {
    st_run,
    st_sleep,
    st_idle_slow_only,
    st_idle_both_osc,
    st_idle_fast_only
  } power_state_e;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic cpu;          // cpu system clock enable
    logic periph_high;  // high clock for peripherals
    logic periph_sub;   // sub clock for peripherals
    logic watchdog;     // watchdog_clk
    logic synth;        // synthesiser system clock running
    logic usb;          // 48 MHz usb clock enable
  } clk_gates_s;

  // oscillator run requests
  typedef struct packed {
    logic fast_rc_osc;
    logic slow_rc_osc;
    logic synth;
  } osc_run_s;

endpackage

// ===== tick_divider.sv
`timescale 1ns/1ps
// divides a tick strobe by 2**ratio_log2, at most 2**cnt_width; restart starts a full new period
module tick_divider #(
  parameter int cnt_width = 6
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic       tick_in,
  input  wire logic       restart,
  input  wire logic [2:0] ratio_log2,
  output logic            tick_out
);
  logic [cnt_width-1:0] cnt_q;   // position inside the period
  logic [cnt_width-1:0] mask;    // terminal count

  // mask = 2**ratio - 1, cut to cnt_width bits
  always_comb begin
    mask = cnt_width'((1 << ratio_log2) - 1);
  end

  // count source ticks, pulse on the last one of each period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= '0;
      tick_out <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        cnt_q    <= '0;
        tick_out <= 1'b0;
      end else if (tick_in) begin
        cnt_q    <= (cnt_q == mask) ? '0 : cnt_q + 1'b1;
        tick_out <= (cnt_q == mask);
      end else begin
        tick_out <= 1'b0;
      end
    end
  end
endmodule // tick_divider

// ===== system_clock_and_power_modes.sv
`timescale 1ns/1ps
module system_clock_and_power_modes (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         ce,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         fast_rc_tick,
  input  wire logic                         slow_rc_tick,
  input  wire logic                         synth_tick,
  input  wire logic                         synth_usb_tick,
  input  wire logic                         halt_req,
  input  wire logic                         wake_req,
  input  wire logic                         watchdog_enable,
  output clock_modes_pkg::clk_gates_s       clk_gates,
  output clock_modes_pkg::osc_run_s         osc_run,
  output logic      [2:0]                   synth_freq_out,
  output logic      [2:0]                   mode
);
  import clock_modes_pkg::*;

  // software registers
  logic [2:0]   sel_q;           // sys_clk_select as written
  logic         fast_idle_q;     // fast_osc_idle_enable
  logic         slow_idle_q;     // slow_osc_idle_enable
  logic         fast_osc_en_q;   // fast rc enable in slow mode
  logic         synth_en_q;      // synth_enable
  logic [2:0]   synth_fsel_q;    // synth_freq_select
  // clock path state
  logic [2:0]   active_sel_q;    // select actually in use
  logic         div_restart;     // restart divider on switch
  logic         high_tick;       // f_h strobe before division
  logic         div_tick;        // divided high strobe
  logic         sys_tick;        // chosen sys_clk strobe
  logic         use_synth;       // high clock from synthesiser
  logic         switch_now;      // safe point for a new select
  power_state_e state_q;         // power state
  logic         fast_on;         // fast rc required
  logic         synth_on;        // synthesiser required
  logic         sub_on;          // sub clock to peripherals
  logic         wdog_on;         // watchdog clock allowed
  logic         usb_on;          // usb may run
  logic [31:0]  rd_word;         // read mux
  logic         rd_hit;          // address is mapped
  logic         apb_done;        // access completes this edge

  // apb: access phase holds one wait cycle, pready comes from a flop
  assign apb_done = psel & penable & pready;

  // read mux; unused bits read as zero
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (paddr)
      off_system_clock_control: begin
        rd_word[sel_lsb +: 3]   = sel_q;
        rd_word[fast_idle_bit]  = fast_idle_q;
        rd_word[slow_idle_bit]  = slow_idle_q;
      end
      off_fast_rc_osc_control: begin
        rd_word[fast_osc_en_bit]  = fast_osc_en_q;
        rd_word[fast_osc_rdy_bit] = osc_run.fast_rc_osc;
      end
      off_freq_synth_control: begin
        rd_word[synth_en_bit]        = synth_en_q;
        rd_word[synth_rdy_bit]       = osc_run.synth;
        rd_word[synth_fsel_lsb +: 3] = synth_fsel_q;
      end
      off_mode_status: begin
        rd_word[2:0] = mode;
        rd_word[5:3] = active_sel_q;
      end
      default: begin
        rd_hit = 1'b0;  // unmapped answers with pslverr
      end
    endcase
  end

  // apb handshake and read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= pwrite ? '0 : rd_word;
        pslverr <= ~rd_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // register writes land at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q         <= sel_reset;
      fast_idle_q   <= 1'b0;
      slow_idle_q   <= 1'b0;
      fast_osc_en_q <= fast_osc_en_rst;
      synth_en_q    <= synth_en_reset;
      synth_fsel_q  <= synth_fsel_rst;
    end else if (ce && apb_done && pwrite) begin
      case (paddr)
        off_system_clock_control: begin
          sel_q       <= pwdata[sel_lsb +: 3];
          fast_idle_q <= pwdata[fast_idle_bit];
          slow_idle_q <= pwdata[slow_idle_bit];
        end
        off_fast_rc_osc_control: begin
          fast_osc_en_q <= pwdata[fast_osc_en_bit];
        end
        off_freq_synth_control: begin
          synth_en_q   <= pwdata[synth_en_bit];
          synth_fsel_q <= pwdata[synth_fsel_lsb +: 3];
        end
        default: begin
          // read-only or unmapped: ignored
        end
      endcase
    end
  end

  // synthesiser drives f_h only for codes 100..110; reserved falls back to fast rc
  assign use_synth = synth_en_q & synth_fsel_q[2] & (synth_fsel_q != fsel_reserved);
  assign high_tick = (use_synth ? synth_tick : fast_rc_tick) & fast_on;

  // the divider restarts on a switch so the first new period is whole
  tick_divider #(
    .cnt_width (6)
  ) u_div (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .tick_in    (high_tick),
    .restart    (div_restart),
    .ratio_log2 (active_sel_q),
    .tick_out   (div_tick)
  );

  // sub clock taken only from slow rc
  assign sys_tick = (active_sel_q == sel_sub) ? slow_rc_tick : div_tick;

  // a new select waits for the end of an old period; with the cpu halted
  // no cpu pulse can be cut, so the change is taken at once
  assign switch_now  = (sel_q != active_sel_q) && (sys_tick || state_q != st_run);
  assign div_restart = switch_now;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_sel_q <= sel_reset;
    end else if (ce && switch_now) begin
      active_sel_q <= sel_q;
    end
  end

  // power state machine; halt chooses mode from the idle bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_run;
    end else if (ce) begin
      case (state_q)
        st_run: begin
          if (halt_req) begin
            case ({fast_idle_q, slow_idle_q})
              2'b00:   state_q <= st_sleep;
              2'b01:   state_q <= st_idle_slow_only;
              2'b11:   state_q <= st_idle_both_osc;
              default: state_q <= st_idle_fast_only;
            endcase
          end
        end
        default: begin
          if (wake_req) begin
            state_q <= st_run;
          end
        end
      endcase
    end
  end

  // oscillator and gate requirements per mode
  always_comb begin
    fast_on  = 1'b1;
    synth_on = synth_en_q;
    sub_on   = 1'b1;
    wdog_on  = 1'b1;
    usb_on   = 1'b1;
    case (state_q)
      st_run: begin
        if (active_sel_q == sel_sub) begin
          fast_on = fast_osc_en_q;
        end
      end
      st_sleep: begin
        fast_on  = 1'b0;
        synth_on = 1'b0;
        sub_on   = 1'b0;
        wdog_on  = watchdog_enable;
        usb_on   = 1'b0;
      end
      st_idle_slow_only: begin
        fast_on  = 1'b0;
        synth_on = 1'b0;
        usb_on   = 1'b0;
      end
      st_idle_both_osc: begin
        fast_on = 1'b1;
      end
      default: begin
        sub_on  = 1'b0;              // fast osc idle: sub clock off, slow osc kept on for the watchdog
      end
    endcase
  end

  // registered gates and oscillator requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_gates      <= '0;
      osc_run        <= '0;
      synth_freq_out <= synth_fsel_rst;
      mode           <= mode_normal;
    end else if (ce) begin
      clk_gates.cpu         <= sys_tick & (state_q == st_run);
      clk_gates.periph_high <= high_tick;
      clk_gates.periph_sub  <= slow_rc_tick & sub_on;
      clk_gates.watchdog    <= slow_rc_tick & wdog_on;
      clk_gates.synth       <= synth_on & fast_on;
      clk_gates.usb         <= synth_usb_tick & synth_on & usb_on;
      osc_run.fast_rc_osc   <= fast_on;
      osc_run.slow_rc_osc   <= sub_on | wdog_on;
      osc_run.synth         <= synth_on & fast_on;
      synth_freq_out        <= synth_fsel_q;
      case (state_q)
        st_run:            mode <= (active_sel_q == sel_sub) ? mode_slow : mode_normal;
        st_sleep:          mode <= mode_sleep;
        st_idle_slow_only: mode <= mode_idle_slow_only;
        st_idle_both_osc:  mode <= mode_idle_both_osc;
        default:           mode <= mode_idle_fast_only;
      endcase
    end
  end

  // checks
  sequence s_halt_sleep;
    ce && state_q == st_run && halt_req && !fast_idle_q && !slow_idle_q;
  endsequence

  property p_sleep_entry;
    @(posedge pclk) disable iff (!presetn)
      s_halt_sleep |=> state_q == st_sleep ##1 (!ce || mode == mode_sleep);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("halt did not enter sleep");

  property p_idle_slow;
    @(posedge pclk) disable iff (!presetn)
      ce && state_q == st_run && halt_req && !fast_idle_q && slow_idle_q
        |=> state_q == st_idle_slow_only;
  endproperty
  a_idle_slow: assert property (p_idle_slow) else $error("slow-only idle not entered");

  property p_idle_both;
    @(posedge pclk) disable iff (!presetn)
      ce && state_q == st_run && halt_req && fast_idle_q && slow_idle_q
        |=> state_q == st_idle_both_osc;
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("both-osc idle not entered");

  property p_idle_fast;
    @(posedge pclk) disable iff (!presetn)
      ce && state_q == st_run && halt_req && fast_idle_q && !slow_idle_q
        |=> state_q == st_idle_fast_only;
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("fast-only idle not entered");

  property p_no_usb;
    @(posedge pclk) disable iff (!presetn)
      ce && (state_q == st_sleep || state_q == st_idle_slow_only) |=> !clk_gates.usb;
  endproperty
  a_no_usb: assert property (p_no_usb) else $error("usb clock in sleep or idle");

  property p_sleep_watchdog;
    @(posedge pclk) disable iff (!presetn)
      ce && state_q == st_sleep && !watchdog_enable |=> !clk_gates.watchdog && !clk_gates.cpu;
  endproperty
  a_sleep_watchdog: assert property (p_sleep_watchdog) else $error("watchdog clock in sleep");

  property p_slow_fast_off;
    @(posedge pclk) disable iff (!presetn)
      ce && state_q == st_run && active_sel_q == sel_sub && !fast_osc_en_q
        |=> !osc_run.fast_rc_osc;
  endproperty
  a_slow_fast_off: assert property (p_slow_fast_off) else $error("fast osc left on");

  property p_switch_edge;
    @(posedge pclk) disable iff (!presetn)
      // a change taken while halted may surface on the wake edge; only run counts
      ce && $past(state_q) == st_run && $changed(active_sel_q) |-> $past(sys_tick);
  endproperty
  a_switch_edge: assert property (p_switch_edge) else $error("select changed mid period");

  property p_wake_mode;
    @(posedge pclk) disable iff (!presetn)
      ce && state_q != st_run && wake_req && active_sel_q == sel_sub && sel_q == sel_sub
        ##1 ce |=> mode == mode_slow;
  endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake did not resume slow");

  property p_synth_reset;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> synth_en_q;
  endproperty
  a_synth_reset: assert property (p_synth_reset) else $error("synth enable not set");

endmodule // system_clock_and_power_modes

// ===== tb_system_clock_and_power_modes.sv
`timescale 1ns/1ps
module tb_system_clock_and_power_modes;
  import clock_modes_pkg::*;

  logic        pclk;            // 250 MHz bus clock
  logic        presetn;         // async reset, low active
  logic        ce;              // clock enable, high except for the freeze test
  logic        psel;            // apb select
  logic        penable;         // apb enable
  logic        pwrite;          // apb direction
  logic [7:0]  paddr;           // apb address
  logic [31:0] pwdata;          // apb write data
  logic [31:0] prdata;          // apb read data
  logic        pready;          // apb ready
  logic        pslverr;         // apb error
  logic        fast_rc_tick;    // fast rc strobe
  logic        slow_rc_tick;    // slow rc strobe
  logic        synth_tick;      // synthesiser strobe
  logic        synth_usb_tick;  // 48 MHz strobe
  logic        halt_req;        // halt pulse
  logic        wake_req;        // wake pulse
  logic        watchdog_enable; // watchdog function on
  clk_gates_s  clk_gates;       // clock enables out
  osc_run_s    osc_run;         // oscillator requests out
  logic [2:0]  synth_freq_out;  // synth select out
  logic [2:0]  mode;            // reported mode
  int          err_total;       // mismatches
  int          cmp_count;       // comparisons
  logic [31:0] rnd;             // lfsr state
  logic [31:0] rdat;            // last read data
  logic        rerr;            // last error flag
  logic        cnt_clr;         // clears the strobe counters
  logic [31:0] n_cpu, n_sub, n_wd, n_usb, n_fast, n_slow, n_syn, n_usbt, n_hi;
  logic [31:0] wval;            // random write word, kept for the compare
  int          sel;             // select under test
  int          idle;            // idle bits under test

  system_clock_and_power_modes dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fast_rc_tick(fast_rc_tick),
    .slow_rc_tick(slow_rc_tick), .synth_tick(synth_tick),
    .synth_usb_tick(synth_usb_tick), .halt_req(halt_req), .wake_req(wake_req),
    .watchdog_enable(watchdog_enable), .clk_gates(clk_gates), .osc_run(osc_run),
    .synth_freq_out(synth_freq_out), .mode(mode)
  );

  // fibonacci lfsr, fixed start so every run is the same
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // mode expected from the idle bits {fast, slow} at halt time
  function automatic logic [2:0] exp_mode(input int i);
    case (i)
      0: return mode_sleep;
      1: return mode_idle_slow_only;
      2: return mode_idle_fast_only;
      default: return mode_idle_both_osc;
    endcase
  endfunction

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // random source strobes; slow rc kept sparser than the fast ones
  always @(posedge pclk) begin
    rnd            <= lfsr(rnd);
    fast_rc_tick   <= rnd[0];
    slow_rc_tick   <= rnd[3] & rnd[7];
    synth_tick     <= rnd[11];
    synth_usb_tick <= rnd[13];
  end

  // strobe counters, one process so nothing else drives them
  always @(posedge pclk) begin
    if (cnt_clr) begin
      {n_cpu, n_sub, n_wd, n_usb} <= '0;
      {n_fast, n_slow, n_syn, n_usbt, n_hi} <= '0;
    end else begin
      n_cpu  <= n_cpu + 32'(clk_gates.cpu);
      n_sub  <= n_sub + 32'(clk_gates.periph_sub);
      n_wd   <= n_wd + 32'(clk_gates.watchdog);
      n_usb  <= n_usb + 32'(clk_gates.usb);
      n_fast <= n_fast + 32'(fast_rc_tick);
      n_slow <= n_slow + 32'(slow_rc_tick);
      n_syn  <= n_syn + 32'(synth_tick);
      n_usbt <= n_usbt + 32'(synth_usb_tick);
      n_hi   <= n_hi + 32'(clk_gates.periph_high);
    end
  end

  task automatic conclude();
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // counts may differ by a few strobes around divider restarts
  task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
    logic ok;
    ok = (got + 32'd3 >= exp) && (got <= exp + 32'd3);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; called just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 64) begin
      err_total++;
      conclude();
    end
    rdat    = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // clear counters, run n cycles, then wait for a falling and the next rising edge
  task automatic measure(input int n);
    cnt_clr <= 1'b1;
    @(posedge pclk);
    cnt_clr <= 1'b0;
    repeat (n) @(posedge pclk);
    @(negedge pclk);
    @(posedge pclk);
  endtask

  task automatic pulse_halt();
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic pulse_wake();
    wake_req <= 1'b1;
    @(posedge pclk);
    wake_req <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // hang guard
  initial begin
    repeat (95000) @(posedge pclk);
    err_total++;
    conclude();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {fast_rc_tick, slow_rc_tick, synth_tick, synth_usb_tick} = '0;
    {halt_req, wake_req, watchdog_enable, cnt_clr} = '0;
    ce = 1'b1;
    rnd = 32'ha9090497;
    err_total = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values and access kinds
    apb(1'b0, off_system_clock_control, '0);
    chk(rdat & 32'he3, 32'h40);
    apb(1'b0, off_fast_rc_osc_control, '0);
    chk(rdat & 32'h01, 32'h01);
    apb(1'b0, off_freq_synth_control, '0);
    chk(rdat & 32'h1d, 32'h01);
    chk(32'(synth_freq_out), 32'(synth_fsel_rst));
    apb(1'b1, off_mode_status, 32'h07);
    apb(1'b0, off_mode_status, '0);
    chk(rdat & 32'h07, 32'(mode_normal));
    apb(1'b0, 8'h10, '0);
    chk({31'h0, rerr}, 32'h1);
    chk(rdat, 32'h0);
    apb(1'b1, 8'h20, 32'hff);
    chk({31'h0, rerr}, 32'h1);
    // clock enable low freezes everything, so a halt pulse is lost
    ce <= 1'b0;
    pulse_halt();
    chk(32'(mode), 32'(mode_normal));
    ce <= 1'b1;
    wval = rnd & 32'hc3;
    apb(1'b1, off_system_clock_control, wval);
    apb(1'b0, off_system_clock_control, '0);
    chk(rdat & 32'he3, wval & 32'he3);
    // every select code, strobe ratio against the source
    for (sel = 0; sel < 8; sel++) begin
      apb(1'b1, off_system_clock_control, 32'(sel) << sel_lsb);
      repeat (300) @(posedge pclk);
      measure(2048);
      if (sel < 7) begin
        chk_near(n_cpu, n_fast >> sel);
        chk(32'(mode), 32'(mode_normal));
        chk(32'(osc_run), 32'h7);
        chk_near(n_usb, n_usbt);
        chk_near(n_hi, n_fast);
      end else begin
        chk_near(n_cpu, n_slow);
        chk(32'(mode), 32'(mode_slow));
      end
      chk_near(n_sub, n_slow);
    end
    // synthesiser as high clock source
    apb(1'b1, off_system_clock_control, 32'(sel_high_div1) << sel_lsb);
    for (int f = 4; f < 8; f++) begin
      apb(1'b1, off_freq_synth_control, 32'h1 | (32'(f) << synth_fsel_lsb));
      repeat (300) @(posedge pclk);
      measure(1024);
      chk(32'(synth_freq_out), 32'(f));
      chk_near(n_cpu, (f == 7) ? n_fast : n_syn);
    end
    apb(1'b1, off_freq_synth_control, 32'(fsel_6mhz) << synth_fsel_lsb);
    repeat (300) @(posedge pclk);
    measure(1024);
    chk_near(n_cpu, n_fast);
    chk(32'(osc_run.synth), 32'h0);
    apb(1'b1, off_freq_synth_control, 32'h1);
    // slow mode: high osc and synth follow their enables
    apb(1'b1, off_system_clock_control, 32'(sel_sub) << sel_lsb);
    repeat (300) @(posedge pclk);
    apb(1'b1, off_fast_rc_osc_control, 32'h0);
    repeat (8) @(posedge pclk);
    chk(32'(osc_run.fast_rc_osc), 32'h0);
    apb(1'b1, off_fast_rc_osc_control, 32'h1);
    repeat (8) @(posedge pclk);
    chk(32'(osc_run.fast_rc_osc), 32'h1);
    apb(1'b1, off_freq_synth_control, 32'h0);
    repeat (8) @(posedge pclk);
    chk(32'({osc_run.synth, clk_gates.synth}), 32'h0);
    apb(1'b1, off_freq_synth_control, 32'h1);
    repeat (8) @(posedge pclk);
    chk(32'(osc_run.synth), 32'h1);
    // halt modes; the fifth pass is sleep with the watchdog on
    for (int i = 0; i < 5; i++) begin
      idle = i % 4;
      sel  = (i == 1) ? 7 : int'(rnd[2:0]);  // one pass always wakes into slow
      watchdog_enable <= (i == 4);
      apb(1'b1, off_system_clock_control, (32'(sel) << sel_lsb) | 32'(idle));
      repeat (300) @(posedge pclk);
      pulse_halt();
      measure(1024);
      chk(32'(mode), 32'(exp_mode(idle)));
      chk(n_cpu, 32'h0);
      chk(32'(osc_run.fast_rc_osc), 32'(idle >= 2));
      if (idle != 2) chk(32'(osc_run.slow_rc_osc), 32'(idle != 0 || i == 4));
      if (idle < 2) chk(n_usb, 32'h0);
      if (idle == 0) chk(n_sub, 32'h0);
      if (idle == 0) chk(32'(n_wd != 0), 32'(i == 4));
      pulse_wake();
      chk(32'(mode), 32'((sel == 7) ? mode_slow : mode_normal));
      pulse_wake();
      chk(32'(mode), 32'((sel == 7) ? mode_slow : mode_normal));
    end
    conclude();
  end
endmodule // tb_system_clock_and_power_modes
